// File: rtl/radio_rx_tx_tuning_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "radio_tuning_regs.svh"

module radio_rx_tx_tuning_regs (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // Avalon-MM slave, byte addressed, data in the low byte
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // From neighbouring logic on the same clock
  input wire logic [2:0] EXT_AMP_MODE_I,
  input wire logic [8:0] CAL_TUNING_I,
  // Settings toward the receive chain
  output logic [23:0] STAGE1_RATE_HZ_O,
  output logic [23:0] STAGE2_RATE_HZ_O,
  output logic [11:0] DEMOD_BW_KHZ_O,
  output logic [8:0] RX_TUNING_O,
  output logic RX_TUNING_OVERRIDE_O,
  output logic [10:0] ANALOG_BW_KHZ_O,
  output logic LNA2_SELECT_O,
  // Settings toward the transmit chain
  output logic [18:0] RAMP_STEP_PS_O,
  output logic [4:0] BRIDGE_BIAS_CODE_O,
  output logic OUTER_AMP_SUPPLY_PIN_O,
  output logic [2:0] OUTER_AMP_BIAS_PIN_O,
  output logic BIAS_DAC_ACTIVE_O,
  output logic [16:0] BIAS_DAC_NA_O,
  output logic SERVO_ACTIVE_O,
  output logic [14:0] SERVO_SET_UA_O,
  output logic AMP_MODE_RESERVED_O
);

  // Whole state of the block
  typedef struct packed {
    radio_tuning_pkg::regfile_type regs;
    radio_tuning_pkg::bus_state_type bus_state;
    logic waitrequest;
    logic [31:0] readdata;
    radio_tuning_pkg::derived_type out;
    logic [8:0] rx_tuning;
    logic override_on;
  } state_type;

  state_type st_reg;
  state_type st_next;
  radio_tuning_pkg::derived_type derived;
  logic [9:0] word_index;
  logic [7:0] read_byte;
  logic [8:0] override_word;
  logic override_en;
  logic write_lane;

  // Word index from the byte address; the two low bits are ignored
  assign word_index = AVS_ADDRESS_I[11:2];
  assign write_lane = AVS_BYTEENABLE_I[0];

  // Nine-bit override word gathered from its two registers
  assign override_word = {st_reg.regs.rx_tuning_override_ctrl[`F_TUNE_MSB],
                          st_reg.regs.rx_tuning_override_low};
  assign override_en = st_reg.regs.rx_tuning_override_ctrl[`F_TUNE_EN];

  // Code translation kept apart so it can be checked on its own
  tuning_decode decode_inst (
    .regs_i(st_reg.regs),
    .ext_amp_mode_i(EXT_AMP_MODE_I),
    .derived_o(derived)
  );

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    read_byte = 8'h00;
    if (word_index == `IDX_RX_DECIM) begin
      read_byte = st_reg.regs.rx_decimation_config;
    end else if (word_index == `IDX_DEMOD_BW) begin
      read_byte = st_reg.regs.demod_filter_bandwidth;
    end else if (word_index == `IDX_TUNE_LOW) begin
      read_byte = st_reg.regs.rx_tuning_override_low;
    end else if (word_index == `IDX_TUNE_CTRL) begin
      read_byte = st_reg.regs.rx_tuning_override_ctrl;
    end else if (word_index == `IDX_RX_FE) begin
      read_byte = st_reg.regs.rx_frontend_config;
    end else if (word_index == `IDX_RAMP) begin
      read_byte = st_reg.regs.amp_ramp_rate;
    end else if (word_index == `IDX_BRIDGE) begin
      read_byte = st_reg.regs.amp_bridge_config;
    end else if (word_index == `IDX_EXT_BIAS) begin
      read_byte = st_reg.regs.external_amp_bias_code;
    end else if (word_index == `IDX_STATUS_TUNE) begin
      // Live tuning value, low eight bits
      read_byte = st_reg.rx_tuning[7:0];
    end else if (word_index == `IDX_STATUS_AMP) begin
      // Live amplifier state, override flag and tuning bit 8 as seen by the analog side
      read_byte = {st_reg.out.mode_reserved,
                   st_reg.out.servo_active,
                   st_reg.out.dac_active,
                   st_reg.out.outer_amp_bias_pin,
                   st_reg.override_on,
                   st_reg.rx_tuning[8]};
    end else begin
      read_byte = 8'h00;
    end
  end

  // Next state: register file, bus handshake and registered outputs
  always_comb begin
    st_next = st_reg;
    // Outputs follow the stored codes one cycle later
    st_next.out = derived;
    st_next.override_on = override_en;
    if (override_en) begin
      st_next.rx_tuning = override_word;
    end else begin
      st_next.rx_tuning = CAL_TUNING_I;
    end
    case (st_reg.bus_state)
      radio_tuning_pkg::BUS_IDLE: begin
        st_next.waitrequest = 1'b1;
        // One wait cycle gives the read data a clean flop stage
        if (AVS_READ_I || AVS_WRITE_I) begin
          st_next.readdata = {24'h000000, read_byte};
          st_next.waitrequest = 1'b0;
          st_next.bus_state = radio_tuning_pkg::BUS_ACK;
        end
      end
      radio_tuning_pkg::BUS_ACK: begin
        // The master samples waitrequest low here, so the write lands now
        if (AVS_WRITE_I && write_lane) begin
          if (word_index == `IDX_RX_DECIM) begin
            st_next.regs.rx_decimation_config = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_DEMOD_BW) begin
            st_next.regs.demod_filter_bandwidth = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_TUNE_LOW) begin
            st_next.regs.rx_tuning_override_low = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_TUNE_CTRL) begin
            st_next.regs.rx_tuning_override_ctrl = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_RX_FE) begin
            st_next.regs.rx_frontend_config = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_RAMP) begin
            st_next.regs.amp_ramp_rate = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_BRIDGE) begin
            st_next.regs.amp_bridge_config = AVS_WRITEDATA_I[7:0];
          end else if (word_index == `IDX_EXT_BIAS) begin
            st_next.regs.external_amp_bias_code = AVS_WRITEDATA_I[7:0];
          end else begin
            // Status words and holes swallow writes silently
            st_next.regs = st_reg.regs;
          end
        end
        st_next.waitrequest = 1'b1;
        st_next.bus_state = radio_tuning_pkg::BUS_IDLE;
      end
      default: begin
        st_next.waitrequest = 1'b1;
        st_next.bus_state = radio_tuning_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register; reset loads the documented defaults
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_reg.regs.rx_decimation_config <= `RST_RX_DECIM;
      st_reg.regs.demod_filter_bandwidth <= `RST_DEMOD_BW;
      st_reg.regs.rx_tuning_override_low <= `RST_TUNE_LOW;
      st_reg.regs.rx_tuning_override_ctrl <= `RST_TUNE_CTRL;
      st_reg.regs.rx_frontend_config <= `RST_RX_FE;
      st_reg.regs.amp_ramp_rate <= `RST_RAMP;
      st_reg.regs.amp_bridge_config <= `RST_BRIDGE;
      st_reg.regs.external_amp_bias_code <= `RST_EXT_BIAS;
      st_reg.bus_state <= radio_tuning_pkg::BUS_IDLE;
      st_reg.waitrequest <= 1'b1;
      st_reg.readdata <= 32'h00000000;
      // Outputs start at zero until the first decode is registered
      st_reg.out <= '0;
      st_reg.rx_tuning <= 9'h000;
      st_reg.override_on <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a flop of the state record
  assign AVS_READDATA_O = st_reg.readdata;
  assign AVS_WAITREQUEST_O = st_reg.waitrequest;
  assign STAGE1_RATE_HZ_O = st_reg.out.stage1_rate_hz;
  assign STAGE2_RATE_HZ_O = st_reg.out.stage2_rate_hz;
  assign DEMOD_BW_KHZ_O = st_reg.out.demod_bw_khz;
  assign RX_TUNING_O = st_reg.rx_tuning;
  assign RX_TUNING_OVERRIDE_O = st_reg.override_on;
  assign ANALOG_BW_KHZ_O = st_reg.out.analog_bw_khz;
  assign LNA2_SELECT_O = st_reg.out.lna2_sel;
  assign RAMP_STEP_PS_O = st_reg.out.ramp_step_ps;
  assign BRIDGE_BIAS_CODE_O = st_reg.out.bridge_bias_code;
  assign OUTER_AMP_SUPPLY_PIN_O = st_reg.out.outer_amp_supply_pin;
  assign OUTER_AMP_BIAS_PIN_O = st_reg.out.outer_amp_bias_pin;
  assign BIAS_DAC_ACTIVE_O = st_reg.out.dac_active;
  assign BIAS_DAC_NA_O = st_reg.out.dac_na;
  assign SERVO_ACTIVE_O = st_reg.out.servo_active;
  assign SERVO_SET_UA_O = st_reg.out.servo_ua;
  assign AMP_MODE_RESERVED_O = st_reg.out.mode_reserved;

endmodule
`default_nettype wire

// File: rtl/radio_tuning_regs.svh
`ifndef RADIO_TUNING_REGS_SVH
`define RADIO_TUNING_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_RX_DECIM 10'h389
`define IDX_DEMOD_BW 10'h38b
`define IDX_TUNE_LOW 10'h395
`define IDX_TUNE_CTRL 10'h396
`define IDX_RX_FE 10'h39b
`define IDX_RAMP 10'h3a7
`define IDX_BRIDGE 10'h3a8
`define IDX_EXT_BIAS 10'h3a9
`define IDX_STATUS_TUNE 10'h3f0
`define IDX_STATUS_AMP 10'h3f1

// Reset values
`define RST_RX_DECIM 8'h05
`define RST_DEMOD_BW 8'hc8
`define RST_TUNE_LOW 8'h00
`define RST_TUNE_CTRL 8'h08
`define RST_RX_FE 8'h1d
`define RST_RAMP 8'h07
`define RST_BRIDGE 8'h0d
`define RST_EXT_BIAS 8'h00

// Field positions
`define F_STAGE2_HI 4
`define F_STAGE2_LO 2
`define F_STAGE1_HI 1
`define F_STAGE1_LO 0
`define F_TUNE_MSB 0
`define F_TUNE_EN 1
`define F_LNA_SEL 4
`define F_ABW_HI 3
`define F_ABW_LO 0
`define F_RAMP_HI 2
`define F_RAMP_LO 0
`define F_BIAS_HI 4
`define F_BIAS_LO 0

// Rates, steps and tables in their own units
`define STAGE1_BASE_HZ 24'd13000000
`define DEMOD_BW_STEP_KHZ 12'd15
`define RAMP_UNIT_PS 19'd2400
`define DAC_BASE_NA 17'd80000
`define DAC_STEP_NA 17'd2580
`define SERVO_BASE_UA 15'd22000
`define SERVO_STEP_UA 15'd349
`define ABW_C15_KHZ 11'd1186
`define ABW_C14_KHZ 11'd1086
`define ABW_C13_KHZ 11'd1029
`define ABW_C12_KHZ 11'd991
`define ABW_C11_KHZ 11'd927
`define ABW_C10_KHZ 11'd867
`define ABW_C9_KHZ 11'd797

`endif

// File: rtl/radio_tuning_pkg.sv
package radio_tuning_pkg;

  // Drive applied to the outer amplifier bias pin
  typedef enum logic [2:0] {
    PIN_FLOAT = 3'h0,
    PIN_SOURCE = 3'h1,
    PIN_SINK = 3'h2,
    PIN_SERVO_POS = 3'h3,
    PIN_SERVO_NEG = 3'h4,
    PIN_RESERVED = 3'h7
  } bias_pin_mode_type;

  // Gray coded bus phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_type;

  typedef struct packed {
    logic [7:0] rx_decimation_config;
    logic [7:0] demod_filter_bandwidth;
    logic [7:0] rx_tuning_override_low;
    logic [7:0] rx_tuning_override_ctrl;
    logic [7:0] rx_frontend_config;
    logic [7:0] amp_ramp_rate;
    logic [7:0] amp_bridge_config;
    logic [7:0] external_amp_bias_code;
  } regfile_type;

  typedef struct packed {
    logic [23:0] stage1_rate_hz;
    logic [23:0] stage2_rate_hz;
    logic [11:0] demod_bw_khz;
    logic [10:0] analog_bw_khz;
    logic lna2_sel;
    logic [18:0] ramp_step_ps;
    logic [4:0] bridge_bias_code;
    logic outer_amp_supply_pin;
    bias_pin_mode_type outer_amp_bias_pin;
    logic dac_active;
    logic [16:0] dac_na;
    logic servo_active;
    logic [14:0] servo_ua;
    logic mode_reserved;
  } derived_type;

endpackage

// File: rtl/tuning_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "radio_tuning_regs.svh"

module tuning_decode (
  input wire radio_tuning_pkg::regfile_type regs_i,
  input wire logic [2:0] ext_amp_mode_i,
  output radio_tuning_pkg::derived_type derived_o
);

  logic [1:0] first_stage_decim_code;
  logic [2:0] second_stage_decim_code;
  logic [3:0] analog_rx_bw_code;
  logic [4:0] bias;

  // Translate register codes into physical settings for the analog side
  always_comb begin
    first_stage_decim_code = regs_i.rx_decimation_config[`F_STAGE1_HI:`F_STAGE1_LO];
    second_stage_decim_code = regs_i.rx_decimation_config[`F_STAGE2_HI:`F_STAGE2_LO];
    analog_rx_bw_code = regs_i.rx_frontend_config[`F_ABW_HI:`F_ABW_LO];
    bias = regs_i.external_amp_bias_code[`F_BIAS_HI:`F_BIAS_LO];
    derived_o = '0;
    derived_o.stage1_rate_hz = `STAGE1_BASE_HZ >> first_stage_decim_code;
    derived_o.stage2_rate_hz = `STAGE1_BASE_HZ >>
      ({2'h0, first_stage_decim_code} + {1'h0, second_stage_decim_code});
    derived_o.demod_bw_khz = 12'({4'h0, regs_i.demod_filter_bandwidth} * `DEMOD_BW_STEP_KHZ);
    derived_o.lna2_sel = regs_i.rx_frontend_config[`F_LNA_SEL];
    derived_o.ramp_step_ps = `RAMP_UNIT_PS << regs_i.amp_ramp_rate[`F_RAMP_HI:`F_RAMP_LO];
    derived_o.bridge_bias_code = regs_i.amp_bridge_config[4:0];
    // Codes below 9 have no characterised bandwidth and report zero
    case (analog_rx_bw_code)
      4'hf: derived_o.analog_bw_khz = `ABW_C15_KHZ;
      4'he: derived_o.analog_bw_khz = `ABW_C14_KHZ;
      4'hd: derived_o.analog_bw_khz = `ABW_C13_KHZ;
      4'hc: derived_o.analog_bw_khz = `ABW_C12_KHZ;
      4'hb: derived_o.analog_bw_khz = `ABW_C11_KHZ;
      4'ha: derived_o.analog_bw_khz = `ABW_C10_KHZ;
      4'h9: derived_o.analog_bw_khz = `ABW_C9_KHZ;
      default: derived_o.analog_bw_khz = 11'h000;
    endcase
    derived_o.dac_na = `DAC_BASE_NA - 17'(`DAC_STEP_NA * {12'h000, bias});
    derived_o.servo_ua = `SERVO_BASE_UA - 15'(`SERVO_STEP_UA * {10'h000, bias});
    // Reserved mode leaves supply off and sets the pin to PIN_RESERVED, with the reserved flag raised
    case (ext_amp_mode_i)
      3'h0: begin
        derived_o.outer_amp_supply_pin = 1'b1;
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_FLOAT;
      end
      3'h1: begin
        derived_o.outer_amp_supply_pin = 1'b1;
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SOURCE;
        derived_o.dac_active = 1'b1;
      end
      3'h2: begin
        derived_o.outer_amp_supply_pin = 1'b1;
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SINK;
        derived_o.dac_active = 1'b1;
      end
      3'h3: begin
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SOURCE;
        derived_o.dac_active = 1'b1;
      end
      3'h4: begin
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SINK;
        derived_o.dac_active = 1'b1;
      end
      3'h5: begin
        derived_o.outer_amp_supply_pin = 1'b1;
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SERVO_POS;
        derived_o.servo_active = 1'b1;
      end
      3'h6: begin
        derived_o.outer_amp_supply_pin = 1'b1;
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_SERVO_NEG;
        derived_o.servo_active = 1'b1;
      end
      default: begin
        derived_o.outer_amp_bias_pin = radio_tuning_pkg::PIN_RESERVED;
        derived_o.mode_reserved = 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

// File: verification/tuning_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the bus handshake and the outputs derived from the side inputs
module tuning_regs_monitor (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [2:0] EXT_AMP_MODE_I,
  input wire logic [8:0] CAL_TUNING_I,
  input wire logic [8:0] RX_TUNING_O,
  input wire logic RX_TUNING_OVERRIDE_O,
  input wire logic OUTER_AMP_SUPPLY_PIN_O,
  input wire logic BIAS_DAC_ACTIVE_O,
  input wire logic [16:0] BIAS_DAC_NA_O,
  input wire logic SERVO_ACTIVE_O,
  input wire logic [14:0] SERVO_SET_UA_O,
  input wire logic AMP_MODE_RESERVED_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Bus answer is fixed at one wait cycle and lasts one cycle
  a_req_acked: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("request not answered after one cycle");
  a_ack_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  a_read_narrow: assert property (!AVS_WAITREQUEST_O && AVS_READ_I |-> AVS_READDATA_O[31:8] == 24'h000000)
    else $error("read data above the byte not zero");

  // Outputs lag their inputs by one edge, so the edge right after reset is skipped
  a_tune_follow: assert property (!$past(SYS_RST_I) && !RX_TUNING_OVERRIDE_O |-> RX_TUNING_O == $past(CAL_TUNING_I))
    else $error("tuning does not follow the calibrated value");
  a_dac_modes: assert property (!$past(SYS_RST_I) |-> BIAS_DAC_ACTIVE_O == ($past(EXT_AMP_MODE_I) inside {[3'h1:3'h4]}))
    else $error("bias current source active in wrong mode");
  a_servo_modes: assert property (!$past(SYS_RST_I) |-> SERVO_ACTIVE_O == ($past(EXT_AMP_MODE_I) inside {3'h5, 3'h6}))
    else $error("servo active in wrong mode");
  a_supply_state: assert property (!$past(SYS_RST_I) |->
    OUTER_AMP_SUPPLY_PIN_O == !($past(EXT_AMP_MODE_I) inside {3'h3, 3'h4, 3'h7}))
    else $error("supply pin state wrong for mode");
  a_mode_rsvd: assert property (!$past(SYS_RST_I) |-> AMP_MODE_RESERVED_O == ($past(EXT_AMP_MODE_I) == 3'h7))
    else $error("reserved mode flag wrong");
  // Both bias figures come from one code, so their offsets scale together
  a_bias_pair: assert property (!$past(SYS_RST_I) |->
    (80000 - BIAS_DAC_NA_O) * 349 == (22000 - SERVO_SET_UA_O) * 2580)
    else $error("bias current and servo set point disagree");
endmodule

bind radio_rx_tx_tuning_regs tuning_regs_monitor u_mon (.MCLK_I, .SYS_RST_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .EXT_AMP_MODE_I, .CAL_TUNING_I, .RX_TUNING_O, .RX_TUNING_OVERRIDE_O,
  .OUTER_AMP_SUPPLY_PIN_O, .BIAS_DAC_ACTIVE_O, .BIAS_DAC_NA_O, .SERVO_ACTIVE_O, .SERVO_SET_UA_O,
  .AMP_MODE_RESERVED_O);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "radio_tuning_regs.svh"
// Counts every comparison and reports a mismatch at once
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
  logic MCLK_I, SYS_RST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
  logic [11:0] AVS_ADDRESS_I;
  logic [3:0] AVS_BYTEENABLE_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
  logic [2:0] EXT_AMP_MODE_I, OUTER_AMP_BIAS_PIN_O;
  logic [8:0] CAL_TUNING_I, RX_TUNING_O;
  logic [23:0] STAGE1_RATE_HZ_O, STAGE2_RATE_HZ_O;
  logic [11:0] DEMOD_BW_KHZ_O;
  logic [10:0] ANALOG_BW_KHZ_O;
  logic [18:0] RAMP_STEP_PS_O;
  logic [4:0] BRIDGE_BIAS_CODE_O;
  logic [16:0] BIAS_DAC_NA_O;
  logic [14:0] SERVO_SET_UA_O;
  logic RX_TUNING_OVERRIDE_O, LNA2_SELECT_O, OUTER_AMP_SUPPLY_PIN_O, BIAS_DAC_ACTIVE_O, SERVO_ACTIVE_O;
  logic AMP_MODE_RESERVED_O;
  logic [7:0] rd;
  int n_mismatch = 0;
  int checks = 0;

  radio_rx_tx_tuning_regs dut (
    .MCLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_BYTEENABLE_I,
    .AVS_WRITEDATA_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .EXT_AMP_MODE_I, .CAL_TUNING_I,
    .STAGE1_RATE_HZ_O, .STAGE2_RATE_HZ_O, .DEMOD_BW_KHZ_O, .RX_TUNING_O, .RX_TUNING_OVERRIDE_O,
    .ANALOG_BW_KHZ_O, .LNA2_SELECT_O, .RAMP_STEP_PS_O, .BRIDGE_BIAS_CODE_O, .OUTER_AMP_SUPPLY_PIN_O,
    .OUTER_AMP_BIAS_PIN_O, .BIAS_DAC_ACTIVE_O, .BIAS_DAC_NA_O, .SERVO_ACTIVE_O, .SERVO_SET_UA_O,
    .AMP_MODE_RESERVED_O
  );

  // One bus transfer; starts on a fresh edge so a release and a new request never share a step
  // Waits as long as the slave asks; only the watchdog ends a hung transfer
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d, input logic be);
    @(posedge MCLK_I);
    AVS_ADDRESS_I <= {idx, 2'h0};
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    AVS_BYTEENABLE_I <= {3'h0, be};
    AVS_WRITEDATA_I <= {24'h000000, d};
    do begin
      @(posedge MCLK_I);
    end while (AVS_WAITREQUEST_O !== 1'b0);
    `CHK("readdata high", 24'h000000, AVS_READDATA_O[31:8])
    rd = AVS_READDATA_O[7:0];
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask

  // Write, then let two edges pass so the derived outputs have settled
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
    repeat (2) @(posedge MCLK_I);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00, 1'b1);
    `CHK("register", ex, rd)
  endtask

  task automatic t_reset();
    rchk(`IDX_RX_DECIM, 8'h05);
    rchk(`IDX_DEMOD_BW, 8'hc8);
    rchk(`IDX_TUNE_LOW, 8'h00);
    rchk(`IDX_TUNE_CTRL, 8'h08);
    rchk(`IDX_RX_FE, 8'h1d);
    rchk(`IDX_RAMP, 8'h07);
    rchk(`IDX_BRIDGE, 8'h0d);
    rchk(`IDX_EXT_BIAS, 8'h00);
    `CHK("stage1", 24'd6500000, STAGE1_RATE_HZ_O)
    `CHK("stage2", 24'd3250000, STAGE2_RATE_HZ_O)
    `CHK("demod", 12'd3000, DEMOD_BW_KHZ_O)
    `CHK("analog", 11'd1029, ANALOG_BW_KHZ_O)
    `CHK("ramp", 19'd307200, RAMP_STEP_PS_O)
    `CHK("tuning", 9'h0a5, RX_TUNING_O)
    `CHK("override", 1'b0, RX_TUNING_OVERRIDE_O)
    `CHK("lna", 1'b1, LNA2_SELECT_O)
    $display("reset defaults done");
  endtask

  // Includes the widest combined shift and code zero
  task automatic t_decim();
    int s1[6] = '{2, 2, 2, 1, 3, 0};
    int s2[6] = '{4, 3, 2, 1, 7, 0};
    for (int i = 0; i < 6; i++) begin
      wr(`IDX_RX_DECIM, {3'h0, 3'(s2[i]), 2'(s1[i])});
      `CHK("stage1", 24'(13000000 >> s1[i]), STAGE1_RATE_HZ_O)
      `CHK("stage2", 24'(13000000 >> (s1[i] + s2[i])), STAGE2_RATE_HZ_O)
    end
    $display("decimation done");
  endtask

  task automatic t_demod();
    int c[9] = '{255, 0, 8, 17, 32, 61, 110, 133, 170};
    for (int i = 0; i < 9; i++) begin
      wr(`IDX_DEMOD_BW, 8'(c[i]));
      `CHK("demod", 12'(c[i] * 15), DEMOD_BW_KHZ_O)
      rchk(`IDX_DEMOD_BW, 8'(c[i]));
    end
    // A write with the low byte lane off must leave the register alone
    bus(1'b1, `IDX_DEMOD_BW, 8'h11, 1'b0);
    rchk(`IDX_DEMOD_BW, 8'haa);
    bus(1'b0, 10'h000, 8'h00, 1'b1);
    `CHK("unmapped", 8'h00, rd)
    $display("demod bandwidth done");
  endtask

  task automatic t_tune();
    wr(`IDX_TUNE_LOW, 8'h3c);
    wr(`IDX_TUNE_CTRL, 8'h09);
    `CHK("tuning", 9'h0a5, RX_TUNING_O)
    CAL_TUNING_I <= 9'h15a;
    repeat (2) @(posedge MCLK_I);
    `CHK("tuning", 9'h15a, RX_TUNING_O)
    wr(`IDX_TUNE_CTRL, 8'h0b);
    `CHK("tuning", 9'h13c, RX_TUNING_O)
    `CHK("override", 1'b1, RX_TUNING_OVERRIDE_O)
    rchk(`IDX_STATUS_TUNE, 8'h3c);
    wr(`IDX_TUNE_CTRL, 8'h0a);
    `CHK("tuning", 9'h03c, RX_TUNING_O)
    wr(`IDX_TUNE_CTRL, 8'h08);
    `CHK("tuning", 9'h15a, RX_TUNING_O)
    $display("tuning override done");
  endtask

  // Codes below nine have no documented bandwidth and read as zero
  task automatic t_analog();
    int kh[8] = '{0, 797, 867, 927, 991, 1029, 1086, 1186};
    for (int i = 0; i < 8; i++) begin
      wr(`IDX_RX_FE, 8'(i == 0 ? 6 : i + 8));
      `CHK("analog", 11'(kh[i]), ANALOG_BW_KHZ_O)
      `CHK("lna", 1'b0, LNA2_SELECT_O)
    end
    $display("analog bandwidth done");
  endtask

  task automatic t_amp();
    for (int c = 0; c < 8; c++) begin
      wr(`IDX_RAMP, 8'(c));
      `CHK("ramp", 19'(2400 << c), RAMP_STEP_PS_O)
    end
    wr(`IDX_BRIDGE, 8'h15);
    `CHK("bridge", 5'd21, BRIDGE_BIAS_CODE_O)
    rchk(`IDX_BRIDGE, 8'h15);
    $display("amplifier ramp and bridge done");
  endtask

  // Largest bias code gives the smallest currents
  task automatic t_ext();
    int pin[8] = '{0, 1, 2, 1, 2, 3, 4, 7};
    wr(`IDX_EXT_BIAS, 8'h1f);
    for (int m = 0; m < 8; m++) begin
      EXT_AMP_MODE_I <= 3'(m);
      repeat (2) @(posedge MCLK_I);
      `CHK("dac on", m inside {[1:4]}, BIAS_DAC_ACTIVE_O)
      `CHK("dac na", 17'(80000 - 2580 * 31), BIAS_DAC_NA_O)
      `CHK("servo on", m inside {5, 6}, SERVO_ACTIVE_O)
      `CHK("servo ua", 15'(22000 - 349 * 31), SERVO_SET_UA_O)
      `CHK("supply", !(m inside {3, 4, 7}), OUTER_AMP_SUPPLY_PIN_O)
      `CHK("pin", 3'(pin[m]), OUTER_AMP_BIAS_PIN_O)
      `CHK("reserved", m == 7, AMP_MODE_RESERVED_O)
      // Override is off and the calibrated value 15a has its top bit set
      rchk(`IDX_STATUS_AMP, {m == 7, m inside {5, 6}, m inside {[1:4]}, 3'(pin[m]), 1'b0, 1'b1});
    end
    // A middle code catches a wrong step that the end code alone might hide
    wr(`IDX_EXT_BIAS, 8'h0d);
    `CHK("dac na", 17'(80000 - 2580 * 13), BIAS_DAC_NA_O)
    `CHK("servo ua", 15'(22000 - 349 * 13), SERVO_SET_UA_O)
    $display("external amplifier done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Clock at 20 MHz
  initial begin
    MCLK_I = 1'b0;
    forever #25 MCLK_I = ~MCLK_I;
  end

  // Main sequence
  initial begin
    SYS_RST_I = 1'b1;
    AVS_ADDRESS_I = 12'h000;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_BYTEENABLE_I = 4'h0;
    AVS_WRITEDATA_I = 32'h00000000;
    EXT_AMP_MODE_I = 3'h0;
    CAL_TUNING_I = 9'h0a5;
    repeat (2) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    t_reset();
    t_decim();
    t_demod();
    t_tune();
    t_analog();
    t_amp();
    t_ext();
    conclude();
  end

  // Whole run needs a few hundred cycles; this bound is far beyond it
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
